// *** core/gcrc_cfg.svh ***
// register offsets, field positions, codes and reset values of the crc unit
`ifndef GCRC_CFG_SVH
`define GCRC_CFG_SVH

`define GCRC_ADDR_BREV     8'h96
`define GCRC_ADDR_AUX      8'hA2
`define GCRC_ADDR_PORT     8'hB6
`define GCRC_ADDR_FMODE    8'hE5
`define GCRC_ADDR_ADRH     8'hE6
`define GCRC_ADDR_ADRL     8'hE7
`define GCRC_ADDR_BOUND    8'hE8
`define GCRC_ADDR_CMD      8'hE9

`define GCRC_SEL_SEED_LO   2'b00
`define GCRC_SEL_SEED_HI   2'b01
`define GCRC_SEL_RSVD      2'b10
`define GCRC_SEL_DATA      2'b11
`define GCRC_AUX_SEL_LSB   4
`define GCRC_AUX_DPTR_BIT  0

`define GCRC_CMD_FIRST     8'h46
`define GCRC_CMD_SECOND    8'hB9

`define GCRC_MODE_STANDBY  8'h00
`define GCRC_MODE_RD       8'h01
`define GCRC_MODE_PROG     8'h02
`define GCRC_MODE_ERASE    8'h03
`define GCRC_MODE_PGP_WR   8'h04
`define GCRC_MODE_PGP_RD   8'h05
`define GCRC_MODE_AUTO     8'h80
`define GCRC_MODE_INC_RD   8'h81
`define GCRC_MODE_INC_PROG 8'h82

`define GCRC_POLY          16'h1021
`define GCRC_END_LOW       9'h1FF
`define GCRC_RST_BYTE      8'h00
`define GCRC_RST_CRC       16'h0000

`endif

// *** core/gcrc_crc_step.sv ***
// one byte of crc16 folding, msb first, no reflection, no final inversion
`timescale 1ns/1ps
`include "gcrc_cfg.svh"
module gcrc_crc_step #(
  parameter logic [15:0] POLY = `GCRC_POLY
) (
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic [15:0]      crc_out
);
  always_comb
  begin
    logic [15:0] c;
    c = crc_in ^ {data_in, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? ((c << 1) ^ POLY) : (c << 1);
    crc_out = c;
  end
endmodule : gcrc_crc_step

// *** core/gcrc_fifo.sv ***
// small valid/ready fifo between the flash reader and the crc datapath
`timescale 1ns/1ps
module gcrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // depth is expected to be a power of two so the pointers wrap naturally
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } gcrc_fifo_t;

  gcrc_fifo_t s;
  gcrc_fifo_t next_s;
  logic       push;
  logic       pop;

  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = AW'(s.wp + 1'b1);
    end
    if (pop)
      next_s.rp = AW'(s.rp + 1'b1);
    if (push && !pop)
      next_s.cnt = (AW+1)'(s.cnt + 1'b1);
    else if (pop && !push)
      next_s.cnt = (AW+1)'(s.cnt - 1'b1);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : gcrc_fifo

// *** core/gcrc_pkg.sv ***
// types shared by the crc unit
package gcrc_pkg;

  typedef enum logic [1:0] {FS_IDLE, FS_ISSUE, FS_WAIT, FS_DRAIN} gcrc_fsm_t;

  typedef enum logic [3:0] {
    FM_STANDBY, FM_BYTE_READ, FM_BYTE_PROG, FM_PAGE_ERASE, FM_PGP_WRITE,
    FM_PGP_READ, FM_AUTO_CRC, FM_INC_READ, FM_INC_PROG, FM_RESERVED
  } gcrc_fmode_t;

  typedef struct packed {
    logic [15:0] crc;
    logic [1:0]  sel;
    logic        dptr;
    logic [7:0]  brev;
    logic [7:0]  mode;
    logic [7:0]  adrh;
    logic [7:0]  adrl;
    logic [6:0]  bound;
    logic        armed;
    gcrc_fsm_t   fsm;
    logic [15:0] addr;
    logic [7:0]  rdata;
  } gcrc_state_t;

endpackage : gcrc_pkg

// *** core/gcrc_top.sv ***
// crc16 unit with seed/data port, flash auto-read path and bit-reverse register
// What this block does
// - remainder uses the sixteen-bit generator 0x1021.
// - every byte written as data input folds into the remainder, back to back.
// - seed high and low bytes overwrite the current remainder.
// - port writes route by select: 00 seed low, 01 seed high, 11 data, 10 ignored.
// - port reads give result low for 00, high for 01, zero otherwise.
// - select field sits in bits 5..4 of the auxiliary control register.
// - a second path feeds bytes read from flash into the remainder.
// - pass starts at address high/low, ends at boundary followed by nine ones.
// - only 0x46 then 0xB9 written to the command register starts the pass, and only with flash mode 0x80 set.
// - flash mode register decodes the listed operation codes, others reserved.
// - bit-reverse register reads back the last written byte mirrored.
`timescale 1ns/1ps
`include "gcrc_cfg.svh"

module gcrc_top
  import gcrc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  output logic             flash_req,
  output logic [15:0]      flash_addr,
  input  wire logic        flash_rvalid,
  input  wire logic [7:0]  flash_rdata,
  output logic             flash_crc_busy,
  output gcrc_fmode_t      flash_mode,
  output logic             dptr_sel
);
  gcrc_state_t s;
  gcrc_state_t next_s;

  logic        wr_port;
  logic        wr_cmd;
  logic        cpu_fold;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;
  logic        fold;
  logic [7:0]  fold_byte;
  logic [15:0] fold_crc;
  logic [15:0] end_addr;
  logic        start_pass;

  assign wr_port  = sfr_wr && (sfr_addr == `GCRC_ADDR_PORT);
  assign wr_cmd   = sfr_wr && (sfr_addr == `GCRC_ADDR_CMD);
  assign cpu_fold = wr_port && (s.sel == `GCRC_SEL_DATA);
  assign end_addr = {s.bound, `GCRC_END_LOW};

  // a processor write to the port owns the remainder this cycle; the flash
  // byte waits in the fifo, so neither source is lost
  assign fifo_out_ready = !wr_port;
  assign fold           = cpu_fold || (fifo_out_valid && fifo_out_ready);
  assign fold_byte      = cpu_fold ? sfr_wdata : fifo_out_data;

  assign start_pass = wr_cmd && s.armed && (sfr_wdata == `GCRC_CMD_SECOND)
                      && (s.mode == `GCRC_MODE_AUTO) && (s.fsm == FS_IDLE);

  assign flash_req      = (s.fsm == FS_ISSUE) && fifo_in_ready;
  assign fifo_in_valid  = (s.fsm == FS_WAIT) && flash_rvalid;
  assign flash_addr     = s.addr;
  assign flash_crc_busy = (s.fsm != FS_IDLE);
  assign sfr_rdata      = s.rdata;
  assign dptr_sel       = s.dptr;

  gcrc_crc_step #(
    .POLY    (`GCRC_POLY)
  ) u_step (
    .crc_in  (s.crc),
    .data_in (fold_byte),
    .crc_out (fold_crc)
  );

  gcrc_fifo #(
    .WIDTH     (8),
    .DEPTH     (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (flash_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb
  begin
    unique case (s.mode)
      `GCRC_MODE_STANDBY:  flash_mode = FM_STANDBY;
      `GCRC_MODE_RD:       flash_mode = FM_BYTE_READ;
      `GCRC_MODE_PROG:     flash_mode = FM_BYTE_PROG;
      `GCRC_MODE_ERASE:    flash_mode = FM_PAGE_ERASE;
      `GCRC_MODE_PGP_WR:   flash_mode = FM_PGP_WRITE;
      `GCRC_MODE_PGP_RD:   flash_mode = FM_PGP_READ;
      `GCRC_MODE_AUTO:     flash_mode = FM_AUTO_CRC;
      `GCRC_MODE_INC_RD:   flash_mode = FM_INC_READ;
      `GCRC_MODE_INC_PROG: flash_mode = FM_INC_PROG;
      default:             flash_mode = FM_RESERVED;
    endcase
  end

  always_comb
  begin
    next_s = s;
    if (fold)
      next_s.crc = fold_crc;
    if (wr_port && (s.sel == `GCRC_SEL_SEED_LO))
      next_s.crc[7:0] = sfr_wdata;
    if (wr_port && (s.sel == `GCRC_SEL_SEED_HI))
      next_s.crc[15:8] = sfr_wdata;
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        `GCRC_ADDR_BREV:  next_s.brev  = {<<{sfr_wdata}};
        `GCRC_ADDR_AUX:
        begin
          next_s.sel = sfr_wdata[`GCRC_AUX_SEL_LSB +: 2];
          next_s.dptr = sfr_wdata[`GCRC_AUX_DPTR_BIT];
        end
        `GCRC_ADDR_FMODE: next_s.mode  = sfr_wdata;
        `GCRC_ADDR_ADRH:  next_s.adrh  = sfr_wdata;
        `GCRC_ADDR_ADRL:  next_s.adrl  = sfr_wdata;
        `GCRC_ADDR_BOUND: next_s.bound = sfr_wdata[6:0];
        `GCRC_ADDR_CMD:   next_s.armed = (sfr_wdata == `GCRC_CMD_FIRST);
        default:          next_s.armed = s.armed;
      endcase
    end
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        `GCRC_ADDR_BREV:  next_s.rdata = s.brev;
        `GCRC_ADDR_AUX:   next_s.rdata = {2'b00, s.sel, 3'b000, s.dptr};
        `GCRC_ADDR_PORT:
          unique case (s.sel)
            `GCRC_SEL_SEED_LO: next_s.rdata = s.crc[7:0];
            `GCRC_SEL_SEED_HI: next_s.rdata = s.crc[15:8];
            default:           next_s.rdata = `GCRC_RST_BYTE;
          endcase
        `GCRC_ADDR_FMODE: next_s.rdata = s.mode;
        `GCRC_ADDR_ADRH:  next_s.rdata = s.adrh;
        `GCRC_ADDR_ADRL:  next_s.rdata = s.adrl;
        `GCRC_ADDR_BOUND: next_s.rdata = {1'b0, s.bound};
        default:          next_s.rdata = `GCRC_RST_BYTE;
      endcase
    end
    unique case (s.fsm)
      FS_IDLE:
        if (start_pass)
        begin
          next_s.addr = {s.adrh, s.adrl};
          next_s.fsm  = FS_ISSUE;
        end
      FS_ISSUE:
        if (fifo_in_ready)
          next_s.fsm = FS_WAIT;
      FS_WAIT:
        if (flash_rvalid)
        begin
          if (s.addr == end_addr)
            next_s.fsm = FS_DRAIN;
          else
          begin
            next_s.addr = 16'(s.addr + 1'b1);
            next_s.fsm  = FS_ISSUE;
          end
        end
      FS_DRAIN:
        if (!fifo_out_valid)
          next_s.fsm = FS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seed_lo_wr_s;
    wr_port && (s.sel == `GCRC_SEL_SEED_LO) && !fifo_out_valid;
  endsequence

  sequence start_cmd_s;
    wr_cmd && (sfr_wdata == `GCRC_CMD_SECOND) && s.armed
      && (s.mode == `GCRC_MODE_AUTO) && (s.fsm == FS_IDLE);
  endsequence

  property start_p;
    start_cmd_s |=> flash_crc_busy && (flash_addr == $past({s.adrh, s.adrl}));
  endproperty

  poly_vector_a: assert property ((s.crc == 16'h0000) && cpu_fold
                                  && (sfr_wdata == 8'h01)
                                  |=> s.crc == `GCRC_POLY)
    else $error("crc of 0x01 from zero is not the generator");
  data_fold_a: assert property (cpu_fold ##1 cpu_fold |=> (s.crc == $past(fold_crc))
                                && ($past(s.crc) == $past(fold_crc, 2)))
    else $error("back to back data bytes lost a fold");
  seed_low_a: assert property (seed_lo_wr_s |=> s.crc[7:0] == $past(sfr_wdata)
                               && s.crc[15:8] == $past(s.crc[15:8]))
    else $error("seed low byte not loaded");
  rsvd_write_a: assert property (wr_port && (s.sel == `GCRC_SEL_RSVD)
                                 |=> $stable(s.crc))
    else $error("reserved select changed the remainder");
  result_high_a: assert property (sfr_rd && (sfr_addr == `GCRC_ADDR_PORT)
                                  && (s.sel == `GCRC_SEL_SEED_HI)
                                  |=> sfr_rdata == $past(s.crc[15:8]))
    else $error("port read with select 01 is not result high");
  sel_field_a: assert property (sfr_wr && (sfr_addr == `GCRC_ADDR_AUX)
                                |=> s.sel == $past(sfr_wdata[5:4]))
    else $error("select field not taken from bits 5..4");
  start_cmd_a: assert property (start_p)
    else $error("command pair did not start the flash pass");
  no_false_start_a: assert property ($rose(flash_crc_busy)
                                     |-> $past(wr_cmd && s.armed
                                     && sfr_wdata == `GCRC_CMD_SECOND))
    else $error("flash pass started without the command pair");
  pass_end_a: assert property ((s.fsm == FS_WAIT) && flash_rvalid
                               && (s.addr == end_addr)
                               |=> (s.fsm == FS_DRAIN) [*1] ##0 !flash_req)
    else $error("pass did not stop at the end address");
  ascend_a: assert property ((s.fsm == FS_WAIT) && flash_rvalid
                             && (s.addr != end_addr)
                             |=> flash_addr == 16'($past(flash_addr) + 1'b1))
    else $error("flash address did not step up by one");
  brev_mirror_a: assert property (sfr_wr && (sfr_addr == `GCRC_ADDR_BREV)
                                  |=> s.brev[7] == $past(sfr_wdata[0])
                                  && s.brev[0] == $past(sfr_wdata[7])
                                  && s.brev[4] == $past(sfr_wdata[3]))
    else $error("bit reverse register not mirrored");
  mode_decode_a: assert property ((s.mode == `GCRC_MODE_AUTO)
                                  |-> flash_mode == FM_AUTO_CRC)
    else $error("auto crc code not decoded");

  // the pair may be split by other register writes; this checks the tight form
  sequence arm_s;
    wr_cmd && (sfr_wdata == `GCRC_CMD_FIRST);
  endsequence

  sequence fire_s;
    wr_cmd && (sfr_wdata == `GCRC_CMD_SECOND) && (s.mode == `GCRC_MODE_AUTO)
      && (s.fsm == FS_IDLE);
  endsequence

  seed_high_a: assert property (wr_port && (s.sel == `GCRC_SEL_SEED_HI)
                                |=> s.crc[15:8] == $past(sfr_wdata)
                                && s.crc[7:0] == $past(s.crc[7:0]))
    else $error("seed high byte not loaded");
  result_low_a: assert property (sfr_rd && (sfr_addr == `GCRC_ADDR_PORT)
                                 && (s.sel == `GCRC_SEL_SEED_LO)
                                 |=> sfr_rdata == $past(s.crc[7:0]))
    else $error("port read with select 00 is not result low");
  rsvd_read_a: assert property (sfr_rd && (sfr_addr == `GCRC_ADDR_PORT)
                                && s.sel[1]
                                |=> sfr_rdata == `GCRC_RST_BYTE)
    else $error("reserved port read did not return zero");
  aux_read_a: assert property (sfr_rd && (sfr_addr == `GCRC_ADDR_AUX)
                               |=> sfr_rdata[5:4] == $past(s.sel))
    else $error("select field not read back in bits 5..4");
  flash_fold_a: assert property (fifo_out_valid && !wr_port
                                 |=> s.crc == $past(fold_crc))
    else $error("flash byte not folded into the remainder");
  req_hold_a: assert property (flash_req
                               |=> (s.fsm == FS_WAIT) && $stable(flash_addr))
    else $error("flash address moved while a read was outstanding");
  drain_idle_a: assert property ((s.fsm == FS_DRAIN) && !fifo_out_valid
                                 |=> !flash_crc_busy)
    else $error("pass did not return to idle after the fifo drained");
  pair_start_a: assert property (arm_s ##1 fire_s |=> flash_crc_busy)
    else $error("back to back command pair did not start the pass");
  disarm_a: assert property (wr_cmd && (sfr_wdata != `GCRC_CMD_FIRST)
                             |=> !s.armed)
    else $error("command write other than the first byte left the unit armed");
  mode_store_a: assert property (sfr_wr && (sfr_addr == `GCRC_ADDR_FMODE)
                                 |=> s.mode == $past(sfr_wdata))
    else $error("flash mode register did not store the written code");
  reserved_decode_a: assert property (!s.mode[7] && (s.mode[6:0] > 7'h05)
                                      |-> flash_mode == FM_RESERVED)
    else $error("unlisted mode code not decoded as reserved");
endmodule : gcrc_top

// *** dv/gcrc_flash_model.sv ***
// behavioural flash that answers the byte reads of the crc unit
`timescale 1ns/1ps
module gcrc_flash_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        flash_req,
  input  wire logic [15:0] flash_addr,
  output logic             flash_rvalid,
  output logic [7:0]       flash_rdata
);
  logic       pend;
  logic [1:0] cnt;
  logic [7:0] val;

  // byte content is a fixed mix of the address, mirrored in the bench
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend <= 1'b0;
      cnt <= 2'h0;
      val <= 8'h00;
      flash_rvalid <= 1'b0;
      flash_rdata <= 8'h00;
    end
    else
    begin
      flash_rvalid <= 1'b0;
      // outside a valid beat the data keeps toggling, nothing to latch by luck
      flash_rdata <= ~flash_rdata;
      if (flash_req)
      begin
        pend <= 1'b1;
        cnt <= slow ? 2'h3 : 2'h0;
        val <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
      end
      else if (pend && cnt == 2'h0)
      begin
        pend <= 1'b0;
        flash_rvalid <= 1'b1;
        flash_rdata <= val;
      end
      else if (pend)
        cnt <= cnt - 2'h1;
    end
  end
endmodule : gcrc_flash_model

// *** dv/gcrc_top_tb.sv ***
// self-checking bench for the crc unit
`timescale 1ns/1ps
`include "gcrc_cfg.svh"
module gcrc_top_tb
  import gcrc_pkg::*;
;
  localparam logic [7:0] BR = `GCRC_ADDR_BREV;
  localparam logic [7:0] AX = `GCRC_ADDR_AUX;
  localparam logic [7:0] PT = `GCRC_ADDR_PORT;
  localparam logic [7:0] FM = `GCRC_ADDR_FMODE;
  localparam logic [7:0] SC = `GCRC_ADDR_CMD;
  logic        clk, rst_b, sfr_wr, sfr_rd, slow, flash_req, flash_rvalid, busy, dptr_sel;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, flash_rdata;
  logic [15:0] flash_addr, ex;
  gcrc_fmode_t flash_mode;
  int          error_cnt, n_tests;
  logic [7:0]  codes [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h80, 8'h81,
                              8'h82, 8'h07};
  gcrc_fmode_t modes [10] = '{FM_STANDBY, FM_BYTE_READ, FM_BYTE_PROG, FM_PAGE_ERASE,
                              FM_PGP_WRITE, FM_PGP_READ, FM_AUTO_CRC, FM_INC_READ,
                              FM_INC_PROG, FM_RESERVED};

  gcrc_top #(.FIFO_DEPTH(4)) i_gcrc_top (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .flash_req(flash_req), .flash_addr(flash_addr), .flash_rvalid(flash_rvalid),
    .flash_rdata(flash_rdata), .flash_crc_busy(busy), .flash_mode(flash_mode),
    .dptr_sel(dptr_sel));
  gcrc_flash_model i_gcrc_flash_model (.clk(clk), .rst_b(rst_b), .slow(slow),
    .flash_req(flash_req), .flash_addr(flash_addr), .flash_rvalid(flash_rvalid),
    .flash_rdata(flash_rdata));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_mode(input gcrc_fmode_t e, input gcrc_fmode_t g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch flash_mode expected %0d seen %0d", e, g);
    end
  endtask : chk_mode

  // strobes stay up between calls so back-to-back writes hit every cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    sfr_rd <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic idle();
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    @(posedge clk);
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    sfr_addr <= a;
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    chk_byte(nm, e, sfr_rdata);
    @(posedge clk);
  endtask : rd

  // leaves the select on the data input, ready for data bytes
  task automatic seed(input logic [15:0] s);
    wr(AX, 8'h00);
    wr(PT, s[7:0]);
    wr(AX, 8'h10);
    wr(PT, s[15:8]);
    wr(AX, 8'h30);
  endtask : seed

  task automatic rcrc(input logic [15:0] e);
    wr(AX, 8'h00);
    rd(PT, e[7:0], "result_low");
    wr(AX, 8'h10);
    rd(PT, e[15:8], "result_high");
  endtask : rcrc

  function automatic logic [15:0] cstep(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : cstep

  task automatic pass(input logic [15:0] st, input logic [6:0] bd, input logic sl);
    logic [15:0] a;
    logic [15:0] e;
    slow <= sl;
    seed(16'h0000);
    wr(AX, 8'h00);
    wr(`GCRC_ADDR_ADRH, st[15:8]);
    wr(`GCRC_ADDR_ADRL, st[7:0]);
    wr(`GCRC_ADDR_BOUND, {1'b0, bd});
    wr(FM, 8'h80);
    wr(SC, 8'h46);
    wr(SC, 8'hB9);
    idle();
    chk_byte("busy", 8'h01, {7'h00, busy});
    for (int n = 0; n < 400 && busy !== 1'b0; n++)
      @(posedge clk);
    chk_byte("busy", 8'h00, {7'h00, busy});
    e = 16'h0000;
    a = st;
    do
    begin
      e = cstep(e, a[7:0] ^ a[15:8] ^ 8'h3C);
      a++;
    end while (a != {bd, 9'h1FF} + 16'h0001);
    rcrc(e);
  endtask : pass

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    {rst_b, sfr_wr, sfr_rd, slow, sfr_addr, sfr_wdata} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(BR, 8'h00, "brev");
    rd(AX, 8'h00, "aux");
    rd(PT, 8'h00, "port");
    rd(FM, 8'h00, "mode");
    wr(BR, 8'hA0);
    rd(BR, 8'h05, "brev");
    wr(BR, 8'h01);
    rd(BR, 8'h80, "brev");
    wr(AX, 8'h31);
    rd(AX, 8'h31, "aux");
    chk_byte("dptr_sel", 8'h01, {7'h00, dptr_sel});
    seed(16'h0000);
    wr(PT, 8'h01);
    rcrc(16'h1021);
    seed(16'hFFFF);
    ex = 16'hFFFF;
    for (int i = 0; i < 9; i++)
    begin
      wr(PT, 8'h31 + 8'(i));
      ex = cstep(ex, 8'h31 + 8'(i));
    end
    rcrc(ex);
    wr(AX, 8'h20);
    wr(PT, 8'h55);
    rd(PT, 8'h00, "port_rsvd");
    wr(AX, 8'h30);
    rd(PT, 8'h00, "port_data");
    rcrc(ex);
    for (int k = 0; k < 10; k++)
    begin
      wr(FM, codes[k]);
      idle();
      chk_mode(modes[k], flash_mode);
    end
    rd(FM, 8'h07, "mode");
    wr(FM, 8'h80);
    wr(SC, 8'hB9);
    wr(SC, 8'h46);
    wr(SC, 8'h00);
    wr(SC, 8'hB9);
    wr(FM, 8'h81);
    wr(SC, 8'h46);
    wr(SC, 8'hB9);
    idle();
    idle();
    chk_byte("busy", 8'h00, {7'h00, busy});
    pass(16'h03F8, 7'h01, 1'b0);
    pass(16'h01F9, 7'h00, 1'b1);
    conclude();
  end
endmodule : gcrc_top_tb
